// [rtl/ggir_top.sv]
// Register slice for two GPIO interrupt groups on the peripheral bus.
// Register map, byte offsets on the controller peripheral bus:
//   00h group a source, 04h group a enable, 08h group a result,
//   14h group b source, 18h group b enable, 1ch group b result.
// Group a implements lines 20..0 and group b lines 26..0. Every other
// position reads zero and drops writes; bit 31 of a result word is the
// software store bit, not a line.
//
// Bus timing: a write lands on the edge that samples i_wr. A read is
// sampled with i_rd and answered one cycle later: o_rvalid pulses for
// one cycle and o_rdata then holds the word until the next read. A read
// and a write in one cycle at one offset return the value before the
// write. Accesses may follow back to back, one per cycle.
//
// Reset: i_rstn clears every flag, enable bit and store bit at once,
// without waiting for a clock edge. The read register clears as well,
// so o_rvalid never pulses out of reset.
//
// Hazard: a trigger that meets a write-one-to-clear of the same flag in
// the same cycle leaves the flag set. Software that races the hardware
// therefore never loses an event, at the cost of possibly seeing a flag
// again right after clearing it.
//
// Limitation: the priority compare lives outside this slice. Each line
// arrives here as one qualification bit, and both that bit and the
// trigger pulses must already be in the bus clock domain; nothing here
// synchronises them.
//
// The result words are deliberately combinational so that a change of
// source, enable or priority reaches the aggregator in the same cycle.
`timescale 1ns/1ps
module ggir_top (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // Controller peripheral bus.
    input wire ggir_pkg::ggir_addr_t i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire ggir_pkg::ggir_word_t i_wdata,
    output ggir_pkg::ggir_word_t o_rdata,
    output logic o_rvalid,
    // Trigger pulses from the per-line edge detectors.
    input wire ggir_pkg::ggir_word_t i_group_a_trigger,
    input wire ggir_pkg::ggir_word_t i_group_b_trigger,
    // Priority qualification, one bit per line, from the priority logic.
    input wire ggir_pkg::ggir_word_t i_group_a_prio_ok,
    input wire ggir_pkg::ggir_word_t i_group_b_prio_ok,
    // Per-line result towards the aggregator.
    output ggir_pkg::ggir_word_t o_group_a_result,
    output ggir_pkg::ggir_word_t o_group_b_result
);
    import ggir_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Address decode, shared by the write strobes and the read mux.
    // Offsets outside the map decode to none, so a stray write there
    // touches no register and a stray read loads zero into the read register.
    function automatic ggir_sel_t ggir_decode(input ggir_addr_t addr);
        ggir_sel_t sel;
        sel = GGIR_SEL_NONE;
        case (addr)
            GGIR_OFS_A_SOURCE: begin
                sel = GGIR_SEL_A_SRC;
            end
            GGIR_OFS_A_ENABLE: begin
                sel = GGIR_SEL_A_EN;
            end
            GGIR_OFS_A_RESULT: begin
                sel = GGIR_SEL_A_RES;
            end
            GGIR_OFS_B_SOURCE: begin
                sel = GGIR_SEL_B_SRC;
            end
            GGIR_OFS_B_ENABLE: begin
                sel = GGIR_SEL_B_EN;
            end
            GGIR_OFS_B_RESULT: begin
                sel = GGIR_SEL_B_RES;
            end
            default: begin
                sel = GGIR_SEL_NONE;
            end
        endcase
        return sel;
    endfunction : ggir_decode

    // Read side state: the returned word and its one-cycle valid pulse.
    // Registered so the bus sees flops, unlike the result words.
    typedef struct packed {
        ggir_word_t rdata;
        logic rvalid;
    } ggir_bus_state_t;

    ggir_bus_state_t state;
    ggir_bus_state_t next_state;
    ggir_sel_t sel;
    ggir_word_t a_source;
    ggir_word_t a_enable;
    ggir_word_t a_result;
    ggir_word_t b_source;
    ggir_word_t b_enable;
    ggir_word_t b_result;

    // One write strobe per writable register.
    logic a_source_wr;
    logic a_enable_wr;
    logic a_result_wr;
    logic b_source_wr;
    logic b_enable_wr;
    logic b_result_wr;

    ////////////////////////////////////////////////////////////////////////
    // Write strobes go to one register only; unmapped writes do nothing.
    // One named strobe per register keeps the offset-to-register mapping
    // in one place instead of spread over the instance connections.
    assign sel = ggir_decode(i_addr);
    assign a_source_wr = i_wr && (sel == GGIR_SEL_A_SRC);
    assign a_enable_wr = i_wr && (sel == GGIR_SEL_A_EN);
    assign a_result_wr = i_wr && (sel == GGIR_SEL_A_RES);
    assign b_source_wr = i_wr && (sel == GGIR_SEL_B_SRC);
    assign b_enable_wr = i_wr && (sel == GGIR_SEL_B_EN);
    assign b_result_wr = i_wr && (sel == GGIR_SEL_B_RES);

    // Group a: lines 20..0 implemented, the rest reserved.
    ggir_group #(
        .IMPL_MASK(GGIR_A_IMPL_MASK)
    ) u_group_a (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_trigger(i_group_a_trigger),
        .i_prio_ok(i_group_a_prio_ok),
        .i_source_wr(a_source_wr),
        .i_enable_wr(a_enable_wr),
        .i_result_wr(a_result_wr),
        .i_wdata(i_wdata),
        .o_source(a_source),
        .o_enable(a_enable),
        .o_result(a_result)
    );

    // Group b: lines 26..0 implemented, the rest reserved.
    ggir_group #(
        .IMPL_MASK(GGIR_B_IMPL_MASK)
    ) u_group_b (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_trigger(i_group_b_trigger),
        .i_prio_ok(i_group_b_prio_ok),
        .i_source_wr(b_source_wr),
        .i_enable_wr(b_enable_wr),
        .i_result_wr(b_result_wr),
        .i_wdata(i_wdata),
        .o_source(b_source),
        .o_enable(b_enable),
        .o_result(b_result)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read path. Data is registered so the bus sees a flop; reserved bits
    // are already zero inside each group, unmapped offsets read zero.
    always_comb begin
        next_state = state;
        next_state.rvalid = i_rd;
        if (i_rd) begin
            case (sel)
                GGIR_SEL_A_SRC: begin
                    next_state.rdata = a_source;
                end
                GGIR_SEL_A_EN: begin
                    next_state.rdata = a_enable;
                end
                GGIR_SEL_A_RES: begin
                    next_state.rdata = a_result;
                end
                GGIR_SEL_B_SRC: begin
                    next_state.rdata = b_source;
                end
                GGIR_SEL_B_EN: begin
                    next_state.rdata = b_enable;
                end
                GGIR_SEL_B_RES: begin
                    next_state.rdata = b_result;
                end
                default: begin
                    next_state.rdata = GGIR_RSVD_VALUE;
                end
            endcase
        end
    end

    // Read register. Reset clears it at once so no read answer is left
    // pending when the bus comes back.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= '{GGIR_RESET_WORD, GGIR_RESET_BIT};
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus outputs come from flops. The result words stay combinational on
    // purpose: a registered copy would add the latch the aggregator forbids.
    assign o_rdata = state.rdata;
    assign o_rvalid = state.rvalid;
    assign o_group_a_result = a_result;
    assign o_group_b_result = b_result;

endmodule : ggir_top

// [rtl/ggir_pkg.sv]
// Package of offsets, field layouts and reset values for the group registers.
package ggir_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus geometry.
    localparam int unsigned GGIR_DATA_W = 32;
    localparam int unsigned GGIR_ADDR_W = 8;

    typedef logic [GGIR_DATA_W-1:0] ggir_word_t;
    typedef logic [GGIR_ADDR_W-1:0] ggir_addr_t;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets on the controller peripheral bus.
    localparam ggir_addr_t GGIR_OFS_A_SOURCE = 8'h00;
    localparam ggir_addr_t GGIR_OFS_A_ENABLE = 8'h04;
    localparam ggir_addr_t GGIR_OFS_A_RESULT = 8'h08;
    localparam ggir_addr_t GGIR_OFS_B_SOURCE = 8'h14;
    localparam ggir_addr_t GGIR_OFS_B_ENABLE = 8'h18;
    localparam ggir_addr_t GGIR_OFS_B_RESULT = 8'h1c;

    ////////////////////////////////////////////////////////////////////////
    // Implemented flag positions; every other position is reserved.
    // Group a: bits 20..0. Group b: bits 26..0. Bit 31 never a flag.
    localparam ggir_word_t GGIR_A_IMPL_MASK = 32'h001f_ffff;
    localparam ggir_word_t GGIR_B_IMPL_MASK = 32'h07ff_ffff;

    // Position of the read/write result storage bit.
    localparam int unsigned GGIR_STORE_POS = 31;

    // Value of reserved bits on read, and reset values.
    localparam ggir_word_t GGIR_RSVD_VALUE = 32'h0000_0000;
    localparam ggir_word_t GGIR_RESET_WORD = 32'h0000_0000;
    localparam logic GGIR_RESET_BIT = 1'h0;

    // Register selector used by the bus decode.
    typedef enum logic [2:0] {
        GGIR_SEL_NONE = 3'h0,
        GGIR_SEL_A_SRC = 3'h1,
        GGIR_SEL_A_EN = 3'h3,
        GGIR_SEL_A_RES = 3'h2,
        GGIR_SEL_B_SRC = 3'h6,
        GGIR_SEL_B_EN = 3'h7,
        GGIR_SEL_B_RES = 3'h5
    } ggir_sel_t;

endpackage : ggir_pkg

// [rtl/ggir_group.sv]
// One interrupt group: sticky source flags, enable bits and result word.
`timescale 1ns/1ps
module ggir_group #(
    parameter ggir_pkg::ggir_word_t IMPL_MASK = ggir_pkg::GGIR_A_IMPL_MASK
) (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // Per-line trigger pulses and priority qualification.
    input wire ggir_pkg::ggir_word_t i_trigger,
    input wire ggir_pkg::ggir_word_t i_prio_ok,
    // Register write strobes and data.
    input wire logic i_source_wr,
    input wire logic i_enable_wr,
    input wire logic i_result_wr,
    input wire ggir_pkg::ggir_word_t i_wdata,
    // Register contents.
    output ggir_pkg::ggir_word_t o_source,
    output ggir_pkg::ggir_word_t o_enable,
    output ggir_pkg::ggir_word_t o_result
);
    import ggir_pkg::*;

    typedef struct packed {
        ggir_word_t source;
        ggir_word_t enable;
        logic result_store_bit;
    } ggir_grp_state_t;

    ggir_grp_state_t state;
    ggir_grp_state_t next_state;
    ggir_word_t clear_mask;

    ////////////////////////////////////////////////////////////////////////
    // Next state. A trigger in the same cycle as a clear keeps the flag set,
    // so no event is lost to a racing write.
    always_comb begin
        next_state = state;
        clear_mask = i_source_wr ? i_wdata : GGIR_RESET_WORD;
        next_state.source = ((state.source & ~clear_mask)
            | i_trigger) & IMPL_MASK;
        if (i_enable_wr) begin
            next_state.enable = i_wdata & IMPL_MASK;
        end
        if (i_result_wr) begin
            next_state.result_store_bit = i_wdata[GGIR_STORE_POS];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register, cleared by system reset.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= '{GGIR_RESET_WORD, GGIR_RESET_WORD,
                GGIR_RESET_BIT};
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // The result is not latched: it follows source, enable and priority.
    assign o_source = state.source;
    assign o_enable = state.enable;
    always_comb begin
        o_result = state.source & state.enable & i_prio_ok
            & IMPL_MASK;
        o_result[GGIR_STORE_POS] = state.result_store_bit;
    end

endmodule : ggir_group

// [verif/ggir_top_sva.sv]
// Checker of the register slice ports.
`timescale 1ns/1ps
module ggir_top_chk (
    // Clock, reset and bus.
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire ggir_pkg::ggir_addr_t i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire ggir_pkg::ggir_word_t i_wdata,
    input wire ggir_pkg::ggir_word_t o_rdata,
    input wire logic o_rvalid,
    // Lines and results.
    input wire ggir_pkg::ggir_word_t i_group_a_trigger,
    input wire ggir_pkg::ggir_word_t i_group_b_trigger,
    input wire ggir_pkg::ggir_word_t i_group_a_prio_ok,
    input wire ggir_pkg::ggir_word_t i_group_b_prio_ok,
    input wire ggir_pkg::ggir_word_t o_group_a_result,
    input wire ggir_pkg::ggir_word_t o_group_b_result
);
    import ggir_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    // Everything here lives in the one bus clock domain.
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    AST_RVALID:
        assert property (i_rd |=> o_rvalid) else $error("no rvalid");
    AST_A_SRC_RSVD:
        assert property (i_rd && i_addr == GGIR_OFS_A_SOURCE
            |=> o_rdata[31:21] == 11'h0) else $error("a source rsvd");
    AST_B_SRC_RSVD:
        assert property (i_rd && i_addr == GGIR_OFS_B_SOURCE
            |=> o_rdata[31:27] == 5'h0) else $error("b source rsvd");
    AST_EN_RSVD:
        assert property (i_rd && i_addr == GGIR_OFS_A_ENABLE
            |=> o_rdata[31:21] == 11'h0) else $error("enable rsvd");
    AST_RES_RSVD:
        assert property (o_group_a_result[30:21] == 10'h0
            && o_group_b_result[30:27] == 4'h0) else $error("result rsvd");
    AST_RES_COMB:
        assert property ((o_group_a_result & ~i_group_a_prio_ok
            & GGIR_A_IMPL_MASK) == 32'h0) else $error("result unqualified");
    AST_STICKY:
        assert property (o_group_b_result[0] && !i_wr ##1
            i_group_b_prio_ok[0] |-> o_group_b_result[0]) else $error("lost");
    AST_STORE:
        assert property (i_wr && i_addr == GGIR_OFS_A_RESULT |=>
            o_group_a_result[31] == $past(i_wdata[31])) else $error("store");
    AST_CLEAR:
        assert property (i_wr && i_addr == GGIR_OFS_A_SOURCE && i_wdata[0]
            && !i_group_a_trigger[0] |=> !o_group_a_result[0])
            else $error("not cleared");
    AST_B_EN_RSVD:
        assert property (i_rd && i_addr == GGIR_OFS_B_ENABLE
            |=> o_rdata[31:27] == 5'h0) else $error("b enable rsvd");
    AST_B_STORE:
        assert property (i_wr && i_addr == GGIR_OFS_B_RESULT |=>
            o_group_b_result[31] == $past(i_wdata[31])) else $error("b store");
endmodule : ggir_top_chk

bind ggir_top ggir_top_chk i_ggir_top_chk (.*);

// [verif/ggir_core_model.sv]
// Bus-master model of the controller core.
`timescale 1ns/1ps
module ggir_core_model (
    // Clock and read return.
    input wire logic i_ref_clk,
    input wire ggir_pkg::ggir_word_t i_rdata,
    input wire logic i_rvalid,
    // Bus request.
    output ggir_pkg::ggir_addr_t o_addr = 8'hff,
    output logic o_wr = 1'b0,
    output logic o_rd = 1'b0,
    output ggir_pkg::ggir_word_t o_wdata = 32'h0
);
    import ggir_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    // Released lines carry the inverse so stale values never look valid.
    task automatic acc(input logic w, input ggir_addr_t a,
                       input ggir_word_t d, output ggir_word_t q,
                       output logic v);
        @(posedge i_ref_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= w;
        o_rd <= !w;
        @(posedge i_ref_clk);
        o_wr <= 1'b0;
        o_rd <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
        #1;
        q = i_rdata;
        v = i_rvalid;
    endtask : acc
endmodule : ggir_core_model

// [verif/tb_ggir_top.sv]
// Self-checking bench of the register slice.
`timescale 1ns/1ps
module tb_ggir_top;
    import ggir_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic wr, rd, rvalid;
    ggir_addr_t addr;
    ggir_word_t wdata, rdata, res_a, res_b, q;
    ggir_word_t trg_a = 32'h0, trg_b = 32'h0, pok_a = 32'h0, pok_b = 32'h0;
    int errors = 0;
    int total_checks = 0;
    ggir_addr_t map [7] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h18, 8'h1c, 8'h40};
    ////////////////////////////////////////////////////////////////////////
    // Clock at 10 MHz.
    always #50 ref_clk = ~ref_clk;
    ggir_top i_ggir_top (.i_ref_clk(ref_clk), .i_rstn(rstn), .i_addr(addr),
        .i_wr(wr), .i_rd(rd), .i_wdata(wdata), .o_rdata(rdata),
        .o_rvalid(rvalid), .i_group_a_trigger(trg_a),
        .i_group_b_trigger(trg_b), .i_group_a_prio_ok(pok_a),
        .i_group_b_prio_ok(pok_b), .o_group_a_result(res_a),
        .o_group_b_result(res_b));
    ggir_core_model i_ggir_core_model (.i_ref_clk(ref_clk), .i_rdata(rdata),
        .i_rvalid(rvalid), .o_addr(addr), .o_wr(wr), .o_rd(rd),
        .o_wdata(wdata));
    // Word compare and bus helpers.
    task automatic chk(input ggir_word_t got, input ggir_word_t exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wreg(input ggir_addr_t a, input ggir_word_t d);
        logic v;
        i_ggir_core_model.acc(1'b1, a, d, q, v);
    endtask : wreg
    task automatic rchk(input ggir_addr_t a, input ggir_word_t e);
        logic v;
        i_ggir_core_model.acc(1'b0, a, 32'h0, q, v);
        chk({31'h0, v}, 32'h1);
        chk(q, e);
    endtask : rchk
    task automatic pulse_reset();
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
    endtask : pulse_reset
    // Every register, and an unmapped place, reads zero after reset.
    task automatic t_reset();
        for (int k = 0; k < 7; k++) rchk(map[k], 32'h0);
        chk(res_a, 32'h0);
        chk(res_b, 32'h0);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_enable();
        wreg(8'h04, 32'hffff_ffff);
        wreg(8'h18, 32'hffff_ffff);
        rchk(8'h04, GGIR_A_IMPL_MASK);
        rchk(8'h18, GGIR_B_IMPL_MASK);
        $display("t_enable done");
    endtask : t_enable
    // One-cycle triggers on every line, reserved ones too.
    task automatic t_source_a();
        @(posedge ref_clk);
        trg_a <= 32'hffff_ffff;
        pok_a <= 32'hffff_ffff;
        @(posedge ref_clk);
        trg_a <= 32'h0;
        rchk(8'h00, GGIR_A_IMPL_MASK);
        chk(res_a, GGIR_A_IMPL_MASK);
        wreg(8'h00, 32'h001f_fff7);
        rchk(8'h00, 32'h8);
        wreg(8'h00, 32'h0);
        rchk(8'h00, 32'h8);
        // Trigger and clear of one flag in one cycle: the set wins.
        fork
            wreg(8'h00, 32'h1);
            begin
                @(posedge ref_clk);
                trg_a <= 32'h1;
                @(posedge ref_clk);
                trg_a <= 32'h0;
            end
        join
        rchk(8'h00, 32'h9);
        @(posedge ref_clk);
        pok_a <= 32'h0;
        #1;
        chk(res_a, 32'h0);
        $display("t_source_a done");
    endtask : t_source_a
    task automatic t_source_b();
        @(posedge ref_clk);
        trg_b <= 32'hffff_ffff;
        pok_b <= 32'hffff_ffff;
        @(posedge ref_clk);
        trg_b <= 32'h0;
        rchk(8'h14, GGIR_B_IMPL_MASK);
        chk(res_b, GGIR_B_IMPL_MASK);
        wreg(8'h14, 32'hffff_ffff);
        rchk(8'h14, 32'h0);
        $display("t_source_b done");
    endtask : t_source_b
    task automatic t_store();
        wreg(8'h08, 32'hffff_ffff);
        chk(res_a, 32'h8000_0000);
        rchk(8'h08, 32'h8000_0000);
        wreg(8'h1c, 32'h7fff_ffff);
        rchk(8'h1c, 32'h0);
        wreg(8'h1c, 32'h8000_0000);
        chk(res_b, 32'h8000_0000);
        rchk(8'h1c, 32'h8000_0000);
        $display("t_store done");
    endtask : t_store
    // Verdict; also reached when the watchdog expires.
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #10000000;
        errors++;
        wrap_up();
    end
    initial begin
        pulse_reset();
        t_reset();
        t_enable();
        t_source_a();
        t_source_b();
        t_store();
        pulse_reset();
        t_reset();
        wrap_up();
    end
endmodule : tb_ggir_top
